// >>> logic/oc_device.sv
// device end: bank of compare channels with dedicated counters
`timescale 1ns/100ps
module oc_device import oc_pkg::*; (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// compare output pins
	output logic [NUM_CH-1:0] pin_o,
	// controller link
	oc_link_if.dev link
);
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_ARMED = 3'h2,
		ST_DONE = 3'h4
	} out_st_t;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic moved;
		logic trig;
		logic pin;
		logic irq;
		logic pm;
		out_st_t st;
	} ch_t;

	typedef struct packed {
		ch_t [NUM_CH-1:0] ch;
	} dev_state_t;

	localparam ch_t CH_RST = '{
		cnt: CNT_RST,
		moved: 1'b0,
		trig: 1'b0,
		pin: RST_PIN,
		irq: 1'b0,
		pm: 1'b0,
		st: ST_IDLE
	};
	localparam dev_state_t DEV_RST = '{ch: {NUM_CH{CH_RST}}};

	// ==========================================================
	// signals
	dev_state_t q;
	dev_state_t d;
	logic [NUM_CH/2:0] pair;
	logic [NUM_CH-1:0] ev;
	logic [NUM_CH-1:0] tick_sel;
	logic [NUM_CH-1:0] sync_md;
	logic [NUM_CH-1:0] trig_md;
	logic [NUM_CH-1:0] casc_lo;
	logic [NUM_CH-1:0] casc_hi;
	logic [NUM_CH-1:0] clr;
	logic [NUM_CH-1:0] inc;
	logic [NUM_CH-1:0] carry;
	logic [NUM_CH-1:0] pmatch;
	logic [NUM_CH-1:0] smatch;
	logic [NUM_CH-1:0] hi_ok_p;
	logic [NUM_CH-1:0] hi_ok_s;
	logic [NUM_CH-1:0] cmp_on;

	// ==========================================================
	// per channel drive and pair detection
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			assign pin_o[g] = q.ch[g].pin;
			assign link.pin[g] = q.ch[g].pin;
			assign link.irq[g] = q.ch[g].irq;
			assign link.trig_stat[g] = q.ch[g].trig;
			assign link.count[g] = q.ch[g].cnt;
			// a pair only forms when both modules ask for it
			if (g % 2 == 0 && g + 1 < NUM_CH) begin : g_pair
				assign pair[g/2] = link.cascade[g] & link.cascade[g+1];
			end
		end
	endgenerate
	assign pair[NUM_CH/2] = 1'b0; // last module has no partner

	// ==========================================================
	// counters, sync/trigger and output sequencing
	always_comb begin
		d = q;
		ev = '0;
		tick_sel = '0;
		sync_md = '0;
		trig_md = '0;
		casc_lo = '0;
		casc_hi = '0;
		clr = '0;
		inc = '0;
		carry = '0;
		pmatch = '0;
		smatch = '0;
		hi_ok_p = '0;
		hi_ok_s = '0;
		cmp_on = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			// pairing, otherwise every module is independent
			casc_lo[i] = (i % 2 == 0) && pair[i/2];
			casc_hi[i] = (i % 2 == 1) && pair[i/2];
			// clock source choice, codes above five tick nothing
			if (int'(link.tbsel[i]) < NUM_TB) begin
				tick_sel[i] = link.tick[link.tbsel[i]];
			end
			// source choice: low codes are this bank's own matches
			if (link.src[i] == SRC_FREE) begin
				ev[i] = 1'b0;
			end else if (int'(link.src[i]) <= NUM_CH) begin
				ev[i] = q.ch[link.src[i] - 5'h01].pm;
			end else begin
				ev[i] = link.evt[link.src[i]];
			end
			sync_md[i] = (link.src[i] != SRC_FREE) && !link.trig_en[i];
			trig_md[i] = (link.src[i] != SRC_FREE) && link.trig_en[i];
			// counter step: the high half follows its low partner
			if (casc_hi[i]) begin
				inc[i] = carry[(i + NUM_CH - 1) % NUM_CH];
				clr[i] = clr[(i + NUM_CH - 1) % NUM_CH];
			end else begin
				clr[i] = (sync_md[i] && ev[i]) || (trig_md[i] && !q.ch[i].trig);
				inc[i] = tick_sel[i] && !clr[i];
			end
			carry[i] = inc[i] && (q.ch[i].cnt == CNT_MAX);
			if (clr[i]) begin
				d.ch[i].cnt = CNT_RST;
			end else if (inc[i]) begin
				d.ch[i].cnt = CNT_W'(q.ch[i].cnt + 16'h0001);
			end
			d.ch[i].moved = (d.ch[i].cnt != q.ch[i].cnt);
			// trigger status: a set in the same cycle beats a clear
			if (trig_md[i] && (ev[i] || link.trig_set[i])) begin
				d.ch[i].trig = 1'b1;
			end else if (link.trig_clr[i] || (link.trig_cfg[i] && carry[i])) begin
				d.ch[i].trig = 1'b0;
			end
			// match against the freshly reached count
			hi_ok_p[i] = !casc_lo[i] ||
				(q.ch[(i + 1) % NUM_CH].cnt == link.primary[(i + 1) % NUM_CH]);
			hi_ok_s[i] = !casc_lo[i] ||
				(q.ch[(i + 1) % NUM_CH].cnt == link.secondary[(i + 1) % NUM_CH]);
			pmatch[i] = q.ch[i].moved && (q.ch[i].cnt == link.primary[i]) && hi_ok_p[i];
			smatch[i] = q.ch[i].moved && (q.ch[i].cnt == link.secondary[i]) && hi_ok_s[i];
			d.ch[i].pm = pmatch[i];
			// output sequencing, only for compare encodings
			cmp_on[i] = !casc_hi[i] && !link.mode[i][MODE_OTHER_BIT] &&
				(link.mode[i] != MODE_OFF);
			d.ch[i].irq = 1'b0;
			if (!cmp_on[i]) begin
				d.ch[i].st = ST_IDLE;
				d.ch[i].pin = RST_PIN;
			end else begin
				case (q.ch[i].st)
					ST_IDLE: begin
						d.ch[i].st = ST_ARMED;
					end
					ST_ARMED: begin
						if (link.mode[i] == MODE_TOGGLE) begin
							if (pmatch[i]) begin
								d.ch[i].pin = ~q.ch[i].pin;
								d.ch[i].irq = 1'b1;
							end
						end else begin
							if (pmatch[i]) begin
								d.ch[i].pin = ~RST_PIN;
							end
							if (smatch[i]) begin
								d.ch[i].pin = RST_PIN;
								d.ch[i].irq = 1'b1;
								if (link.mode[i] == MODE_DBL_ONE) begin
									d.ch[i].st = ST_DONE;
								end
							end
						end
					end
					ST_DONE: begin
						if (link.rearm[i]) begin
							d.ch[i].st = ST_ARMED;
						end
					end
					default: begin
						d.ch[i].st = ST_IDLE;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			q <= DEV_RST;
		end else begin
			q <= d;
		end
	end
endmodule

// >>> common/oc_pkg.sv
// constants and field layout shared by both ends of the output compare bank
// Operation
// - nine independent compare modules, each own counter
// - free-run counter counts up, wraps to zero
// - event when counter equals primary or secondary
// - sync mode runs once clock source ticks
// - sync mode: source event clears the counter
// - trigger mode holds counter until trigger event
// - zero source select means free-running, default
// - trigger enable bit seven picks trigger mode
// - source select picks one of 31 sources
// - default: every module counts on its own
// - cascade: even module low, odd module high
// - low counter wrap increments paired high counter
// - software sets cascade bit in both modules
// - three-bit field picks one of six clocks
// - single-shot, continuous and toggle compare outputs
// - software loads rising and falling match values
// - period must be at least the secondary value
// - compare modes have mode field top bit clear
// - trigger config and software-settable trigger status
// - double modes: secondary match restores default level
// - flag on primary single, secondary double match
// - single-shot once, rearmed by first control write
package oc_pkg;
	// ==========================================================
	// sizes
	localparam int NUM_CH = 9;
	localparam int CNT_W = 16;
	localparam int NUM_TB = 6;
	localparam int TB_W = 3;
	localparam int SRC_W = 5;
	localparam int NUM_SRC = 32;
	localparam int MODE_W = 3;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	// ==========================================================
	// values
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
	localparam logic [SRC_W-1:0] SRC_FREE = 5'h00;
	localparam logic RST_PIN = 1'b0;
	// ==========================================================
	// compare mode encodings, top bit set means non-compare
	localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
	localparam logic [MODE_W-1:0] MODE_TOGGLE = 3'h1;
	localparam logic [MODE_W-1:0] MODE_DBL_ONE = 3'h2;
	localparam logic [MODE_W-1:0] MODE_DBL_CONT = 3'h3;
	localparam int MODE_OTHER_BIT = 2;
	// ==========================================================
	// first_control_reg and second_control_reg fields
	localparam int C1_MODE_LSB = 0;
	localparam int C1_TCFG_BIT = 3;
	localparam int C1_TB_LSB = 10;
	localparam int C2_SRC_LSB = 0;
	localparam int C2_TSTAT_BIT = 6;
	localparam int C2_TEN_BIT = 7;
	localparam int C2_CASC_BIT = 8;
	// status word bits
	localparam int ST_PIN_BIT = 0;
	localparam int ST_TRIG_BIT = 1;
	localparam int ST_PERR_BIT = 2;
	// ==========================================================
	// register slots inside each channel's eight-word window
	localparam logic [2:0] REG_CON1 = 3'h0;
	localparam logic [2:0] REG_CON2 = 3'h1;
	localparam logic [2:0] REG_PRI = 3'h2;
	localparam logic [2:0] REG_SEC = 3'h3;
	localparam logic [2:0] REG_PER = 3'h4;
	localparam logic [2:0] REG_CNT = 3'h5;
	localparam logic [2:0] REG_STAT = 3'h6;
endpackage

// >>> common/oc_link_if.sv
// link between the compare bank and its controlling end
`timescale 1ns/100ps
interface oc_link_if;
	import oc_pkg::*;
	// configuration from the controller
	logic [NUM_CH-1:0][MODE_W-1:0] mode;
	logic [NUM_CH-1:0][TB_W-1:0] tbsel;
	logic [NUM_CH-1:0] trig_cfg;
	logic [NUM_CH-1:0][SRC_W-1:0] src;
	logic [NUM_CH-1:0] trig_en;
	logic [NUM_CH-1:0] cascade;
	logic [NUM_CH-1:0][CNT_W-1:0] primary;
	logic [NUM_CH-1:0][CNT_W-1:0] secondary;
	// one-cycle commands
	logic [NUM_CH-1:0] rearm;
	logic [NUM_CH-1:0] trig_set;
	logic [NUM_CH-1:0] trig_clr;
	// clock source ticks and external sync sources
	logic [NUM_TB-1:0] tick;
	logic [NUM_SRC-1:0] evt;
	// state back from the bank
	logic [NUM_CH-1:0] pin;
	logic [NUM_CH-1:0] irq;
	logic [NUM_CH-1:0] trig_stat;
	logic [NUM_CH-1:0][CNT_W-1:0] count;

	modport dev (
		input mode, tbsel, trig_cfg, src, trig_en, cascade, primary, secondary,
		input rearm, trig_set, trig_clr, tick, evt,
		output pin, irq, trig_stat, count
	);
	modport host (
		output mode, tbsel, trig_cfg, src, trig_en, cascade, primary, secondary,
		output rearm, trig_set, trig_clr, tick, evt,
		input pin, irq, trig_stat, count
	);
endinterface

// >>> logic/oc_host.sv
// controller end: software registers driving the compare bank
`timescale 1ns/100ps
module oc_host import oc_pkg::*; (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// software register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	// clock sources and sync sources
	input wire logic [NUM_TB-1:0] tick_i,
	input wire logic [NUM_SRC-1:0] evt_i,
	// compare events seen by the controller
	output logic [NUM_CH-1:0] irq_o,
	// bank link
	oc_link_if.host link
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [NUM_CH-1:0][MODE_W-1:0] mode;
		logic [NUM_CH-1:0][TB_W-1:0] tbsel;
		logic [NUM_CH-1:0] tcfg;
		logic [NUM_CH-1:0][SRC_W-1:0] src;
		logic [NUM_CH-1:0] ten;
		logic [NUM_CH-1:0] casc;
		logic [NUM_CH-1:0][CNT_W-1:0] prim;
		logic [NUM_CH-1:0][CNT_W-1:0] sec;
		logic [NUM_CH-1:0][CNT_W-1:0] per;
		logic [NUM_CH-1:0] rearm;
		logic [NUM_CH-1:0] tset;
		logic [NUM_CH-1:0] tclr;
		logic [NUM_TB-1:0] tick;
		logic [NUM_SRC-1:0] evt;
		logic [DATA_W-1:0] rdata;
		logic [NUM_CH-1:0] irq;
	} host_state_t;

	host_state_t q;
	host_state_t d;
	logic [3:0] ch;
	logic [2:0] slot;
	logic hit;
	logic [DATA_W-1:0] word;

	assign ch = addr_i[ADDR_W-1:3];
	assign slot = addr_i[2:0];
	assign hit = (int'(ch) < NUM_CH);

	// ==========================================================
	// register write and read decode
	always_comb begin
		d = q;
		word = REG_RST;
		d.rearm = '0;
		d.tset = '0;
		d.tclr = '0;
		d.tick = tick_i;
		d.evt = evt_i;
		d.irq = link.irq;
		d.rdata = REG_RST;
		if (wr_i && hit) begin
			case (slot)
				REG_CON1: begin
					d.mode[ch] = wdata_i[C1_MODE_LSB +: MODE_W];
					d.tcfg[ch] = wdata_i[C1_TCFG_BIT];
					d.tbsel[ch] = wdata_i[C1_TB_LSB +: TB_W];
					d.rearm[ch] = 1'b1;
				end
				REG_CON2: begin
					d.src[ch] = wdata_i[C2_SRC_LSB +: SRC_W];
					d.ten[ch] = wdata_i[C2_TEN_BIT];
					d.casc[ch] = wdata_i[C2_CASC_BIT];
					// software trigger or clear of the trigger status
					d.tset[ch] = wdata_i[C2_TSTAT_BIT];
					d.tclr[ch] = ~wdata_i[C2_TSTAT_BIT];
				end
				REG_PRI: d.prim[ch] = wdata_i;
				REG_SEC: d.sec[ch] = wdata_i;
				REG_PER: d.per[ch] = wdata_i;
				default: ;
			endcase
		end
		if (rd_i && hit) begin
			case (slot)
				REG_CON1: begin
					word[C1_MODE_LSB +: MODE_W] = q.mode[ch];
					word[C1_TCFG_BIT] = q.tcfg[ch];
					word[C1_TB_LSB +: TB_W] = q.tbsel[ch];
				end
				REG_CON2: begin
					word[C2_SRC_LSB +: SRC_W] = q.src[ch];
					word[C2_TSTAT_BIT] = link.trig_stat[ch];
					word[C2_TEN_BIT] = q.ten[ch];
					word[C2_CASC_BIT] = q.casc[ch];
				end
				REG_PRI: word = q.prim[ch];
				REG_SEC: word = q.sec[ch];
				REG_PER: word = q.per[ch];
				REG_CNT: word = link.count[ch];
				REG_STAT: begin
					word[ST_PIN_BIT] = link.pin[ch];
					word[ST_TRIG_BIT] = link.trig_stat[ch];
					word[ST_PERR_BIT] = (q.per[ch] < q.sec[ch]);
				end
				default: ;
			endcase
			d.rdata = word;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// link and port drive, all from flip-flops
	assign link.mode = q.mode;
	assign link.tbsel = q.tbsel;
	assign link.trig_cfg = q.tcfg;
	assign link.src = q.src;
	assign link.trig_en = q.ten;
	assign link.cascade = q.casc;
	assign link.primary = q.prim;
	assign link.secondary = q.sec;
	assign link.rearm = q.rearm;
	assign link.trig_set = q.tset;
	assign link.trig_clr = q.tclr;
	assign link.tick = q.tick;
	assign link.evt = q.evt;
	assign rdata_o = q.rdata;
	assign irq_o = q.irq;
endmodule

// >>> tb/oc_link_sva.sv
// link checker for channel 0 and the pair 2/3
`timescale 1ns/100ps
module oc_link_sva import oc_pkg::*; (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// configuration from the controller
	input wire logic [NUM_CH-1:0][MODE_W-1:0] mode,
	input wire logic [NUM_CH-1:0][TB_W-1:0] tbsel,
	input wire logic [NUM_CH-1:0][SRC_W-1:0] src,
	input wire logic [NUM_CH-1:0] trig_en,
	input wire logic [NUM_CH-1:0] trig_set,
	input wire logic [NUM_CH-1:0] cascade,
	input wire logic [NUM_CH-1:0][CNT_W-1:0] primary,
	input wire logic [NUM_CH-1:0][CNT_W-1:0] secondary,
	input wire logic [NUM_TB-1:0] tick,
	input wire logic [NUM_SRC-1:0] evt,
	// state from the bank
	input wire logic [NUM_CH-1:0] pin,
	input wire logic [NUM_CH-1:0] irq,
	input wire logic [NUM_CH-1:0] trig_stat,
	input wire logic [NUM_CH-1:0][CNT_W-1:0] count
);
	// ==========
	// channel 0 and pair 2/3 conditions
	logic act, solo, step, ext, pair;
	assign act = mode[0] != MODE_OFF && !mode[0][MODE_OTHER_BIT];
	assign solo = act && !(cascade[0] && cascade[1]);
	assign step = tbsel[0] < 3'h6 && tick[tbsel[0]];
	assign ext = src[0] >= 5'h0a && evt[src[0]];
	assign pair = cascade[2] && cascade[3] && src[2] == SRC_FREE;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);
	// ==========
	// counter and sources
	count_step_a: assert property (solo && src[0] == SRC_FREE && step
		|=> count[0] == $past(count[0]) + 16'h0001)
		else $error("counter missed a step");
	sync_clear_a: assert property (solo && !trig_en[0] && ext |=> count[0] == CNT_RST)
		else $error("sync event did not clear counter");
	trig_hold_a: assert property ((solo && src[0] != SRC_FREE && trig_en[0] && !trig_stat[0]) [*2]
		|-> count[0] == CNT_RST)
		else $error("counter ran before trigger");
	trig_set_a: assert property (solo && src[0] != SRC_FREE && trig_en[0]
		&& (trig_set[0] || ext) |=> trig_stat[0])
		else $error("trigger status not set");
	// ==========
	// matches, output, pair carry and reset
	toggle_hit_a: assert property (solo && mode[0] == MODE_TOGGLE && $changed(count[0])
		&& count[0] == primary[0] |=> pin[0] != $past(pin[0]) && irq[0])
		else $error("toggle match missed");
	dbl_fall_a: assert property (solo && mode[0] == MODE_DBL_CONT && primary[0] != secondary[0]
		&& $changed(count[0]) && count[0] == secondary[0] |=> !pin[0] && irq[0])
		else $error("secondary match did not restore pin");
	idle_pin_a: assert property ((!act) [*2] |-> !pin[0] && !irq[0])
		else $error("idle channel drove pin or flag");
	irq_pulse_a: assert property (irq[0] |=> !irq[0])
		else $error("flag longer than one cycle");
	carry_a: assert property (pair && $changed(count[3])
		|-> count[2] <= 16'h0001 && count[3] == $past(count[3]) + 16'h0001)
		else $error("high half moved without carry");
	rst_clear_a: assert property ($fell(srst_i) |-> count == '0 && pin == '0)
		else $error("reset left counter or pin set");
endmodule

// >>> tb/test_output_compare_sync_trigger.sv
// self-checking bench for the compare bank and its controller
`timescale 1ns/100ps
`define CHK(nm, e, g) \
	compares++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("wrong value %s exp %h got %h", nm, e, g); \
	end
module test_output_compare_sync_trigger import oc_pkg::*;;
	// ==========
	// stimulus and observed signals
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [NUM_TB-1:0] tick = '0;
	logic [NUM_SRC-1:0] evt = '0;
	logic [DATA_W-1:0] rdata;
	logic [NUM_CH-1:0] irq;
	logic [NUM_CH-1:0] pin;
	logic [DATA_W-1:0] q;
	int n_fail = 0;
	int compares = 0;
	int p, s, n, t, k;
	logic pp;
	int n_irq = 0;
	oc_link_if i_link();
	oc_host i_oc_host(.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
		.rd_i(rd_s), .rdata_o(rdata), .tick_i(tick), .evt_i(evt), .irq_o(irq), .link(i_link.host));
	oc_device i_oc_device(.clk_sys_i(clk_sys_i), .srst_i(srst_i), .pin_o(pin), .link(i_link.dev));
	oc_link_sva i_oc_link_sva(.clk_sys_i(clk_sys_i), .srst_i(srst_i), .mode(i_link.mode), .tbsel(i_link.tbsel),
		.src(i_link.src), .trig_en(i_link.trig_en), .trig_set(i_link.trig_set), .cascade(i_link.cascade),
		.primary(i_link.primary), .secondary(i_link.secondary), .tick(i_link.tick), .evt(i_link.evt),
		.pin(i_link.pin), .irq(i_link.irq), .trig_stat(i_link.trig_stat), .count(i_link.count));
	// clock
	initial begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// flag pulses of the low module of pair 2/3
	always @(posedge clk_sys_i) begin
		if (irq[2]) begin
			n_irq <= n_irq + 1;
		end
	end
	// ==========
	// control words
	function automatic logic [15:0] c1(input int m, input int tb);
		return 16'((m & 7) | (tb << 10));
	endfunction
	function automatic logic [15:0] c2(input int sr, input int ten, input int ts, input int cs);
		return 16'(sr | (ts << 6) | (ten << 7) | (cs << 8));
	endfunction
	// ==========
	// register port and source drivers
	task automatic wr(input int ch, input int sl, input logic [15:0] d);
		@(posedge clk_sys_i);
		addr <= 7'(ch * 8 + sl);
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_sys_i);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input int ch, input int sl);
		@(posedge clk_sys_i);
		addr <= 7'(ch * 8 + sl);
		rd_s <= 1'b1;
		@(posedge clk_sys_i);
		rd_s <= 1'b0;
		@(posedge clk_sys_i);
		q = rdata;
	endtask
	// exactly n steps on source b, other sources random when r is set
	task automatic tk(input int b, input int n, input bit r);
		int c;
		logic [31:0] v;
		c = 0;
		while (c < n) begin
			@(posedge clk_sys_i);
			v = r ? $urandom : '1;
			tick <= v[5:0];
			c += v[b];
		end
		@(posedge clk_sys_i);
		tick <= '0;
		repeat (4) @(posedge clk_sys_i);
	endtask
	task automatic ev(input int e);
		@(posedge clk_sys_i);
		evt <= 32'h0000_0001 << e;
		@(posedge clk_sys_i);
		evt <= '0;
		repeat (4) @(posedge clk_sys_i);
	endtask
	// counter cleared through a sync event
	task automatic zc(input int ch);
		wr(ch, 1, c2(10, 0, 0, 0));
		ev(10);
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// watchdog, the cascade wrap alone takes some 65600 cycles
	initial begin
		repeat (90000) @(posedge clk_sys_i);
		n_fail++;
		end_of_test();
	end
	// ==========
	// test sequence
	initial begin
		void'($urandom(7153));
		repeat (20) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		rd(3, 5);
		`CHK("reset count", 16'h0000, q)
		rd(9, 0);
		`CHK("unmapped read", 16'h0000, q)
		$display("test reset done");
		for (int md = 2; md < 4; md++) begin
			p = 2 + $urandom % 20;
			s = p + 1 + $urandom % 20;
			wr(0, 2, 16'(p));
			wr(0, 3, 16'(s));
			wr(0, 4, 16'(s));
			wr(0, 0, c1(md, 0));
			zc(0);
			wr(0, 1, 16'h0000);
			n = p + $urandom % (s - p);
			tk(0, n, 1);
			rd(0, 6);
			`CHK("pin between matches", 1'b1, q[ST_PIN_BIT])
			tk(0, s - n, 1);
			rd(0, 6);
			`CHK("pin after secondary", 1'b0, q[ST_PIN_BIT])
			`CHK("period error", 1'b0, q[ST_PERR_BIT])
		end
		$display("test double done");
		t = $urandom % 6;
		p = 1 + $urandom % 40;
		wr(0, 2, 16'(p));
		wr(0, 0, c1(1, t));
		zc(0);
		wr(0, 1, 16'h0000);
		n = 1 + $urandom % 60;
		tk(t, n, 1);
		rd(0, 5);
		`CHK("free count", 16'(n), q)
		rd(0, 6);
		`CHK("toggled pin", n >= p, q[ST_PIN_BIT])
		$display("test toggle done");
		k = 10 + $urandom % 22;
		wr(0, 1, c2(k, 0, 0, 0));
		tk(t, 5, 1);
		ev(k);
		tk(t, 3, 1);
		rd(0, 5);
		`CHK("sync count", 16'h0003, q)
		$display("test sync done");
		for (int i = 0; i < 2; i++) begin
			wr(0, 1, c2(k, 1, 0, 0));
			tk(t, 4, 1);
			rd(0, 5);
			`CHK("held count", 16'h0000, q)
			if (i == 0) begin
				ev(k);
			end else begin
				wr(0, 1, c2(k, 1, 1, 0));
			end
			tk(t, 4, 1);
			rd(0, 5);
			`CHK("triggered count", 16'h0004, q)
			rd(0, 6);
			`CHK("trigger status", 1'b1, q[ST_TRIG_BIT])
		end
		$display("test trigger done");
		// channel 0 stays triggered until its counter wraps in the cascade run
		wr(0, 0, c1(1, t) | (16'h0001 << C1_TCFG_BIT));
		for (int c = 2; c < 4; c++) begin
			wr(c, 0, c1(1, 0));
			zc(c);
		end
		wr(2, 2, 16'h0003);
		wr(3, 2, 16'h0001);
		wr(3, 1, c2(0, 0, 0, 1));
		wr(2, 1, c2(0, 0, 0, 1));
		pp = pin[2];
		k = n_irq;
		tk(0, 65539, 0);
		rd(2, 5);
		`CHK("low half", 16'h0003, q)
		rd(3, 5);
		`CHK("high half", 16'h0001, q)
		`CHK("pair pin", ~pp, pin[2])
		`CHK("pair flag", 1, n_irq - k)
		rd(0, 5);
		`CHK("auto clear count", 16'h0000, q)
		rd(0, 6);
		`CHK("auto clear status", 1'b0, q[ST_TRIG_BIT])
		$display("test cascade done");
		// reset in mid-run with counters and pins away from zero
		@(posedge clk_sys_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		rd(2, 5);
		`CHK("count after reset", 16'h0000, q)
		`CHK("pin after reset", 9'h000, pin)
		$display("test restart done");
		end_of_test();
	end
endmodule
